// ---- common/tweep_consts.svh ----
// Constants for the two-wire EEPROM slave and its bus master
`ifndef TWEEP_CONSTS_SVH
`define TWEEP_CONSTS_SVH
`define TWEEP_DEV_CODE       4'ha
`define TWEEP_PAGE_SMALL     8
`define TWEEP_PAGE_LARGE     16
`define TWEEP_WRITE_TIME_NS  10000000
`define TWEEP_CLK_NS         4
`define TWEEP_WR_CYCLES      (`TWEEP_WRITE_TIME_NS / `TWEEP_CLK_NS)
`define TWEEP_SCL_HALF       16
`define TWEEP_ERASED         8'hff
`define TWEEP_REG_CTRL       12'h000
`define TWEEP_REG_ADDR       12'h004
`define TWEEP_REG_WDATA      12'h008
`define TWEEP_REG_STAT       12'h00c
`define TWEEP_REG_RDATA      12'h010
`define TWEEP_CTRL_GO        0
`define TWEEP_CTRL_START     1
`define TWEEP_CTRL_STOP      2
`define TWEEP_CTRL_READ      3
`define TWEEP_CTRL_NACK      4
`define TWEEP_STAT_BUSY      0
`define TWEEP_STAT_ACK       1
`endif

// ---- common/tweep_pkg.sv ----
// Types shared by both ends of the two-wire EEPROM link
package tweep_pkg;
    typedef enum logic [2:0] {
        TWEEP_IDLE  = 3'b000,
        TWEEP_DEVA  = 3'b001,
        TWEEP_WADR  = 3'b011,
        TWEEP_WDAT  = 3'b010,
        TWEEP_RDAT  = 3'b110,
        TWEEP_SKIP  = 3'b111
    } tweep_sl_state_t;
    typedef enum logic [2:0] {
        TWEEP_M_IDLE  = 3'b000,
        TWEEP_M_START = 3'b001,
        TWEEP_M_BITS  = 3'b011,
        TWEEP_M_ACK   = 3'b010,
        TWEEP_M_STOP  = 3'b110
    } tweep_ms_state_t;
endpackage

// ---- common/tweep_if.sv ----
// Two-wire bus between the master and the EEPROM slave
`timescale 1ns/100ps
interface tweep_if;
    logic scl;
    logic scl_m_out;
    logic scl_m_oe_n;
    logic sda_m_out;
    logic sda_m_oe_n;
    logic sda_s_out;
    logic sda_s_oe_n;
    // Open-drain wired AND with pull-ups
    assign scl = scl_m_oe_n ? 1'b1 : scl_m_out;
    wire sda = (sda_m_oe_n ? 1'b1 : sda_m_out)
             & (sda_s_oe_n ? 1'b1 : sda_s_out);
    modport master (input scl, input sda, output scl_m_out,
                    output scl_m_oe_n, output sda_m_out,
                    output sda_m_oe_n);
    modport slave (input scl, input sda, output sda_s_out,
                   output sda_s_oe_n);
endinterface

// ---- rtl/tweep_slave.sv ----
// EEPROM slave: protocol engine, array and write cycle
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "tweep_consts.svh"
module tweep_slave
    import tweep_pkg::*;
#(
    parameter int AW        = 9,
    parameter int WR_CYCLES = `TWEEP_WR_CYCLES
)(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Straps and protect
    input  wire logic         strap_addr_bit0,
    input  wire logic         strap_addr_bit1,
    input  wire logic         strap_addr_bit2,
    input  wire logic         write_protect,
    // Status
    output logic              wr_busy_ff,
    // Bus
    tweep_if.slave            bus
);
    localparam int DEPTH = 1 << AW;
    localparam int PLOG  = (AW == 9) ? 4 : 3;
    localparam int PAGE  = 1 << PLOG;
    if (AW < 7 || AW > 9) $error("AW must be 7..9");

    logic [7:0]     mem [DEPTH];
    logic [7:0]     page_buf [PAGE];
    logic [PAGE-1:0] page_vld_ff;
    logic [1:0]     scl_sy_ff, sda_sy_ff;
    logic [1:0]     wp_sy_ff;
    logic [2:0]     strap_s1_ff, strap_s2_ff;
    logic           scl_d_ff, sda_d_ff;
    tweep_sl_state_t st_ff;
    logic [3:0]     bit_ff;
    logic [7:0]     sh_ff;
    logic           ack_ph_ff;
    logic           rd_ack_ff;
    logic [AW-1:0]  ptr_ff;
    logic [AW-1:0]  wbase_ff;
    logic           wr_pend_ff;
    logic [31:0]    wcnt_ff;
    logic           sda_oe_n_ff;
    logic [AW-1:0]  wr_ptr_ff;
    logic [PLOG:0]  wr_idx_ff;

    wire scl = scl_sy_ff[1];
    wire sda = sda_sy_ff[1];
    wire scl_rise = scl & ~scl_d_ff;
    wire scl_fall = ~scl & scl_d_ff;
    wire start_det = scl & scl_d_ff & sda_d_ff & ~sda;
    wire stop_det  = scl & scl_d_ff & ~sda_d_ff & sda;
    wire [7:0] rx_byte = {sh_ff[6:0], sda};
    // Device code compare on the upper four bits
    wire code_ok = sh_ff[7:4] == `TWEEP_DEV_CODE;
    // Three-strap compare; two straps for large part
    wire strap_ok = (AW == 9) ?
        (sh_ff[3:2] == strap_s2_ff[2:1]) :
        (sh_ff[3:1] == strap_s2_ff);
    wire block_select_bit = sh_ff[1];
    wire [AW-1:0] in_page_nxt = {ptr_ff[AW-1:PLOG],
                                 ptr_ff[PLOG-1:0] + 1'b1};

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            scl_sy_ff <= 2'b11;
            sda_sy_ff <= 2'b11;
            wp_sy_ff  <= 2'h0;
            strap_s1_ff <= 3'h0;
            strap_s2_ff <= 3'h0;
            scl_d_ff  <= 1'b1;
            sda_d_ff  <= 1'b1;
        end
        else
        begin
            scl_sy_ff <= {scl_sy_ff[0], bus.scl};
            sda_sy_ff <= {sda_sy_ff[0], bus.sda};
            wp_sy_ff  <= {wp_sy_ff[0], write_protect};
            strap_s1_ff <= {strap_addr_bit2, strap_addr_bit1,
                            strap_addr_bit0};
            strap_s2_ff <= strap_s1_ff;
            scl_d_ff  <= scl;
            sda_d_ff  <= sda;
        end

    assign bus.sda_s_out  = 1'b0;
    assign bus.sda_s_oe_n = sda_oe_n_ff;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            st_ff       <= TWEEP_IDLE;
            bit_ff      <= 4'h0;
            sh_ff       <= 8'h00;
            ack_ph_ff   <= 1'b0;
            rd_ack_ff   <= 1'b0;
            ptr_ff      <= '0;
            wbase_ff    <= '0;
            wr_pend_ff  <= 1'b0;
            page_vld_ff <= '0;
            sda_oe_n_ff <= 1'b1;
        end
        else if (wr_busy_ff)
        begin
            // Bus ignored, no ack while programming
            st_ff       <= TWEEP_IDLE;
            sda_oe_n_ff <= 1'b1;
            wr_pend_ff  <= 1'b0;
        end
        else if (start_det)
        begin
            st_ff       <= TWEEP_DEVA;
            bit_ff      <= 4'h0;
            ack_ph_ff   <= 1'b0;
            sda_oe_n_ff <= 1'b1;
            page_vld_ff <= '0;
        end
        else if (stop_det)
        begin
            st_ff       <= TWEEP_IDLE;
            sda_oe_n_ff <= 1'b1;
            wr_pend_ff  <= (st_ff == TWEEP_WDAT) && (|page_vld_ff);
        end
        else if (scl_rise && st_ff != TWEEP_IDLE && st_ff != TWEEP_SKIP)
        begin
            if (ack_ph_ff)
                rd_ack_ff <= ~sda;
            else
                sh_ff <= rx_byte;
            if (!ack_ph_ff)
                bit_ff <= bit_ff + 4'h1;
        end
        else if (scl_fall && st_ff != TWEEP_IDLE && st_ff != TWEEP_SKIP)
        begin
            if (!ack_ph_ff && bit_ff == 4'h8)
            begin
                ack_ph_ff <= 1'b1;
                bit_ff    <= 4'h0;
                sda_oe_n_ff <= 1'b1;
                unique case (st_ff)
                    TWEEP_DEVA:
                        if (code_ok && strap_ok)
                            sda_oe_n_ff <= 1'b0;
                        else
                            st_ff <= TWEEP_SKIP;
                    TWEEP_WADR:
                    begin
                        ptr_ff <= (AW == 9) ?
                            AW'({wbase_ff[AW-1], sh_ff}) : AW'(sh_ff);
                        sda_oe_n_ff <= 1'b0;
                    end
                    TWEEP_WDAT:
                    begin
                        page_buf[ptr_ff[PLOG-1:0]] <= sh_ff;
                        page_vld_ff[ptr_ff[PLOG-1:0]] <= 1'b1;
                        // Only in-page bits step in writes
                        ptr_ff <= in_page_nxt;
                        sda_oe_n_ff <= 1'b0;
                    end
                    TWEEP_RDAT:
                    begin
                        ptr_ff <= ptr_ff + 1'b1;
                    end
                    default:
                        st_ff <= TWEEP_SKIP;
                endcase
            end
            else if (ack_ph_ff)
            begin
                ack_ph_ff   <= 1'b0;
                sda_oe_n_ff <= 1'b1;
                unique case (st_ff)
                    TWEEP_DEVA:
                        if (sh_ff[0])
                        begin
                            st_ff <= TWEEP_RDAT;
                            sda_oe_n_ff <= mem[ptr_ff][7];
                        end
                        else
                        begin
                            st_ff <= TWEEP_WADR;
                            wbase_ff <= AW'({block_select_bit, 8'h00});
                        end
                    TWEEP_WADR:
                    begin
                        st_ff <= TWEEP_WDAT;
                        wbase_ff <= ptr_ff;
                    end
                    TWEEP_WDAT:
                        st_ff <= TWEEP_WDAT;
                    TWEEP_RDAT:
                        // No ack from master ends output
                        if (rd_ack_ff)
                            sda_oe_n_ff <= mem[ptr_ff][7];
                        else
                            st_ff <= TWEEP_SKIP;
                    default:
                        st_ff <= TWEEP_SKIP;
                endcase
            end
            else if (st_ff == TWEEP_RDAT)
            begin
                // Next data bit, MSB first
                sda_oe_n_ff <= mem[ptr_ff][3'(7 - bit_ff)];
            end
        end

    // Internal write cycle and array update
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            wr_busy_ff <= 1'b0;
            wcnt_ff    <= 32'h0;
            wr_ptr_ff  <= '0;
            wr_idx_ff  <= '0;
        end
        else if (wr_pend_ff && !wr_busy_ff)
        begin
            wr_busy_ff <= 1'b1;
            wcnt_ff    <= 32'(WR_CYCLES);
            wr_ptr_ff  <= wbase_ff;
            wr_idx_ff  <= '0;
        end
        else if (wr_busy_ff)
        begin
            if (wr_idx_ff < (PLOG+1)'(PAGE))
            begin
                wr_idx_ff <= wr_idx_ff + 1'b1;
                wr_ptr_ff <= {wr_ptr_ff[AW-1:PLOG],
                              wr_ptr_ff[PLOG-1:0] + 1'b1};
            end
            if (wcnt_ff <= 32'h1)
                wr_busy_ff <= 1'b0;
            wcnt_ff <= wcnt_ff - 32'h1;
        end

    wire do_prog = wr_busy_ff && !wp_sy_ff[1] &&
                   wr_idx_ff < (PLOG+1)'(PAGE) &&
                   page_vld_ff[wr_ptr_ff[PLOG-1:0]];

    always_ff @(posedge pclk)
        if (do_prog)
            mem[wr_ptr_ff] <= page_buf[wr_ptr_ff[PLOG-1:0]];
endmodule

// ---- rtl/tweep_master.sv ----
// APB-controlled two-wire bus master
`timescale 1ns/100ps
`include "tweep_consts.svh"
module tweep_master
    import tweep_pkg::*;
#(
    parameter int HALF = `TWEEP_SCL_HALF
)(
    // APB
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Bus
    tweep_if.master           bus
);
    if (HALF < 2) $error("HALF too small");
    tweep_ms_state_t st_ff;
    logic [4:0]  ctl_ff;
    logic [7:0]  tx_ff, rx_ff;
    logic [3:0]  bit_ff;
    logic [15:0] div_ff;
    logic        phase_ff;
    logic        scl_ff, sda_ff, ack_ff, busy_ff;
    logic [1:0]  sda_sy_ff;
    logic [31:0] prdata_ff;
    logic        sda_in;
    assign sda_in = sda_sy_ff[1];
    wire acc  = psel & penable;
    wire wr   = acc & pwrite;
    wire go   = wr && paddr == `TWEEP_REG_CTRL && pwdata[`TWEEP_CTRL_GO];
    wire tick = div_ff == 16'(HALF - 1);
    wire [31:0] rd_mux =
        (paddr == `TWEEP_REG_STAT)  ? {30'h0, ack_ff, busy_ff} :
        (paddr == `TWEEP_REG_RDATA) ? {24'h0, rx_ff} :
        (paddr == `TWEEP_REG_WDATA) ? {24'h0, tx_ff} :
        (paddr == `TWEEP_REG_CTRL)  ? {27'h0, ctl_ff} : 32'h0;
    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign bus.scl_m_out  = 1'b0;
    assign bus.scl_m_oe_n = scl_ff;
    assign bus.sda_m_out  = 1'b0;
    assign bus.sda_m_oe_n = sda_ff;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            prdata_ff <= 32'h0;
            sda_sy_ff <= 2'b11;
        end
        else
        begin
            prdata_ff <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_ff;
            sda_sy_ff <= {sda_sy_ff[0], bus.sda};
        end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            st_ff <= TWEEP_M_IDLE;
            ctl_ff <= 5'h0;
            tx_ff <= 8'h0;
            rx_ff <= 8'h0;
            bit_ff <= 4'h0;
            div_ff <= 16'h0;
            phase_ff <= 1'b0;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            ack_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `TWEEP_REG_WDATA && !busy_ff)
                tx_ff <= pwdata[7:0];
            if (go && !busy_ff)
            begin
                ctl_ff <= pwdata[4:0];
                busy_ff <= 1'b1;
                div_ff <= 16'h0;
                phase_ff <= 1'b0;
                bit_ff <= 4'h0;
                st_ff <= pwdata[`TWEEP_CTRL_START] ? TWEEP_M_START
                                                   : TWEEP_M_BITS;
            end
            else if (busy_ff)
            begin
                div_ff <= tick ? 16'h0 : div_ff + 16'h1;
                if (tick)
                begin
                    phase_ff <= ~phase_ff;
                    unique case (st_ff)
                        TWEEP_M_START:
                            // SCL low to free SDA, SCL high, then pull SDA
                            if (!phase_ff)
                            begin
                                scl_ff <= 1'b0;
                                sda_ff <= 1'b1;
                            end
                            else if (!scl_ff)
                            begin
                                scl_ff <= 1'b1;
                                phase_ff <= 1'b1;
                            end
                            else
                            begin
                                sda_ff <= 1'b0;
                                st_ff <= TWEEP_M_BITS;
                            end
                        TWEEP_M_BITS, TWEEP_M_ACK:
                            if (!phase_ff)
                            begin
                                // SCL low: change SDA
                                scl_ff <= 1'b0;
                                if (st_ff == TWEEP_M_BITS)
                                    sda_ff <= ctl_ff[`TWEEP_CTRL_READ] ?
                                        1'b1 : tx_ff[3'(7 - bit_ff)];
                                else
                                    sda_ff <= ~ctl_ff[`TWEEP_CTRL_READ]
                                        | ctl_ff[`TWEEP_CTRL_NACK];
                            end
                            else
                            begin
                                scl_ff <= 1'b1;
                                if (st_ff == TWEEP_M_BITS)
                                begin
                                    rx_ff <= {rx_ff[6:0], sda_in};
                                    bit_ff <= bit_ff + 4'h1;
                                    if (bit_ff == 4'h7)
                                        st_ff <= TWEEP_M_ACK;
                                end
                                else
                                begin
                                    ack_ff <= ~sda_in;
                                    if (ctl_ff[`TWEEP_CTRL_STOP])
                                        st_ff <= TWEEP_M_STOP;
                                    else
                                    begin
                                        st_ff <= TWEEP_M_IDLE;
                                        busy_ff <= 1'b0;
                                    end
                                end
                            end
                        TWEEP_M_STOP:
                            if (!phase_ff)
                            begin
                                scl_ff <= 1'b0;
                                sda_ff <= 1'b0;
                            end
                            else if (!scl_ff)
                            begin
                                scl_ff <= 1'b1;
                                phase_ff <= 1'b1;
                            end
                            else
                            begin
                                sda_ff <= 1'b1;
                                st_ff <= TWEEP_M_IDLE;
                                busy_ff <= 1'b0;
                            end
                        default:
                            busy_ff <= 1'b0;
                    endcase
                end
            end
        end
endmodule

// ---- bench/tweep_bus_properties.sv ----
// Concurrent checks on the two-wire link between master and slave
`timescale 1ns/100ps
module tweep_bus_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus lines
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_m_oe_n,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_oe_n,
    // Slave status
    input wire logic wr_busy_ff
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_busy_silent;
        wr_busy_ff |-> sda_s_oe_n;
    endproperty
    a_busy_silent: assert property (p_busy_silent)
        else $error("slave drove sda during write cycle");
    property p_slave_scl_low;
        $changed(sda_s_oe_n) |-> !scl;
    endproperty
    a_slave_scl_low: assert property (p_slave_scl_low)
        else $error("slave changed sda while scl high");
    property p_start_release;
        (scl && $past(scl) && $fell(sda)) |-> sda_s_oe_n [*8];
    endproperty
    a_start_release: assert property (p_start_release)
        else $error("slave drove sda after start");
    property p_stop_release;
        (scl && $past(scl) && $rose(sda)) |-> sda_s_oe_n [*8];
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("slave drove sda after stop");
    property p_drive_hold;
        $fell(sda_s_oe_n) |=> !sda_s_oe_n [*8];
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("slave drive too short");
    property p_scl_low_phase;
        $fell(scl) |-> !scl [*8];
    endproperty
    a_scl_low_phase: assert property (p_scl_low_phase)
        else $error("scl low phase too short");
    property p_scl_high_phase;
        $rose(scl) |-> scl [*8];
    endproperty
    a_scl_high_phase: assert property (p_scl_high_phase)
        else $error("scl high phase too short");
    property p_busy_after_stop;
        $rose(wr_busy_ff) |-> scl && sda;
    endproperty
    a_busy_after_stop: assert property (p_busy_after_stop)
        else $error("write cycle began without stop");
    property p_busy_ends;
        $rose(wr_busy_ff) |-> ##[1:1000] !wr_busy_ff;
    endproperty
    a_busy_ends: assert property (p_busy_ends)
        else $error("write cycle did not end");
    property p_start_by_master;
        (scl && $past(scl) && $fell(sda)) |-> !sda_m_oe_n && scl_m_oe_n;
    endproperty
    a_start_by_master: assert property (p_start_by_master)
        else $error("start not made by master");
    property p_stop_by_master;
        (scl && $past(scl) && $rose(sda)) |-> $rose(sda_m_oe_n);
    endproperty
    a_stop_by_master: assert property (p_stop_by_master)
        else $error("stop not made by master");
endmodule

// ---- bench/tweep_bench.sv ----
// Self-checking bench: APB master driving the EEPROM slave
`timescale 1ns/100ps
`include "tweep_consts.svh"
module tweep_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wp;
    logic        strap0;
    logic        strap1;
    logic        busy;
    logic [31:0] q;
    int          n_mismatch;
    int          checked;
    int          cyc;
    int          i;
    logic [7:0]  bad [3] = '{8'hac, 8'ha0, 8'hb4};
    localparam logic [7:0] C_GO = 8'h01 << `TWEEP_CTRL_GO;
    localparam logic [7:0] C_ST = 8'h01 << `TWEEP_CTRL_START;
    localparam logic [7:0] C_SP = 8'h01 << `TWEEP_CTRL_STOP;
    localparam logic [7:0] C_RD = 8'h01 << `TWEEP_CTRL_READ;
    localparam logic [7:0] C_NK = 8'h01 << `TWEEP_CTRL_NACK;
    tweep_if bus ();
    tweep_master #(.HALF(16)) tweep_master_inst (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .bus(bus));
    tweep_slave #(.AW(9), .WR_CYCLES(900)) tweep_slave_inst (.pclk,
        .presetn, .strap_addr_bit0(strap0), .strap_addr_bit1(strap1),
        .strap_addr_bit2(1'b0), .write_protect(wp), .wr_busy_ff(busy),
        .bus(bus));
    tweep_bus_properties tweep_bus_properties_inst (.pclk, .presetn,
        .scl(bus.scl), .sda(bus.sda), .scl_m_oe_n(bus.scl_m_oe_n),
        .sda_m_oe_n(bus.sda_m_oe_n), .sda_s_oe_n(bus.sda_s_oe_n),
        .wr_busy_ff(busy));
    always #2 pclk = ~pclk;
    task report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_mismatch++;
            report_and_stop;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task op(input logic [7:0] c, input logic [7:0] d, output logic ack,
            output logic [7:0] rd);
        logic [31:0] r;
        apb(1'b1, `TWEEP_REG_WDATA, {24'h0, d}, r);
        apb(1'b1, `TWEEP_REG_CTRL, {24'h0, c | C_GO}, r);
        r = 32'h1;
        while (r[`TWEEP_STAT_BUSY] !== 1'b0)
            apb(1'b0, `TWEEP_REG_STAT, 32'h0, r);
        ack = r[`TWEEP_STAT_ACK];
        apb(1'b0, `TWEEP_REG_RDATA, 32'h0, r);
        rd = r[7:0];
    endtask
    task send(input logic [7:0] c, input logic [7:0] d, input logic ea);
        logic       a;
        logic [7:0] r;
        op(c, d, a, r);
        chk({31'h0, a}, {31'h0, ea});
    endtask
    task recv(input logic [7:0] c, input logic [7:0] exp);
        logic       a;
        logic [7:0] r;
        op(c, 8'h00, a, r);
        chk({24'h0, r}, {24'h0, exp});
    endtask
    task wait_done;
        logic       a;
        logic [7:0] r;
        int         k;
        a = 1'b0;
        k = 0;
        while (a !== 1'b1 && k < 20)
        begin
            op(C_ST | C_SP, 8'ha4, a, r);
            k++;
        end
        chk({31'h0, a}, 32'h1);
    endtask
    task set_ptr(input logic [7:0] dev, input logic [7:0] w);
        send(C_ST, dev, 1'b1);
        send(8'h00, w, 1'b1);
    endtask
    task t_byte;
        set_ptr(8'ha4, 8'h00);
        send(C_SP, 8'h5a, 1'b1);
        send(C_ST | C_SP, 8'ha5, 1'b0);
        wait_done;
        set_ptr(8'ha4, 8'h00);
        send(C_ST, 8'ha5, 1'b1);
        recv(C_RD | C_NK | C_SP, 8'h5a);
    endtask
    task t_page;
        set_ptr(8'ha6, 8'h20);
        for (i = 0; i < 17; i++)
            send((i == 16) ? C_SP : 8'h00, 8'(i + 1), 1'b1);
        wait_done;
        set_ptr(8'ha6, 8'h20);
        send(C_ST, 8'ha7, 1'b1);
        for (i = 0; i < 15; i++)
            recv((i == 14) ? (C_RD | C_NK | C_SP) : C_RD,
                 (i == 0) ? 8'd17 : 8'(i + 1));
        send(C_ST, 8'ha5, 1'b1);
        recv(C_RD | C_NK | C_SP, 8'd16);
    endtask
    task t_wrap;
        set_ptr(8'ha6, 8'hff);
        send(C_SP, 8'h77, 1'b1);
        wait_done;
        set_ptr(8'ha6, 8'hff);
        send(C_ST, 8'ha7, 1'b1);
        recv(C_RD, 8'h77);
        recv(C_RD | C_NK | C_SP, 8'h5a);
    endtask
    task t_protect;
        wp <= 1'b1;
        set_ptr(8'ha6, 8'h20);
        send(C_SP, 8'hee, 1'b1);
        wait_done;
        wp <= 1'b0;
        set_ptr(8'ha6, 8'h20);
        send(C_ST, 8'ha7, 1'b1);
        recv(C_RD | C_NK | C_SP, 8'd17);
    endtask
    task t_nomatch;
        for (i = 0; i < 3; i++)
            send(C_ST | C_SP, bad[i], 1'b0);
        send(C_ST | C_SP, 8'ha4, 1'b1);
        apb(1'b0, 12'h020, 32'h0, q);
        chk(q, 32'h0);
        strap0 <= 1'b1;
        send(C_ST | C_SP, 8'ha4, 1'b1);
        strap1 <= 1'b0;
        send(C_ST | C_SP, 8'ha4, 1'b0);
        send(C_ST | C_SP, 8'ha0, 1'b1);
    endtask
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wp = 1'b0;
        strap0 = 1'b0;
        strap1 = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_byte;
        t_page;
        t_wrap;
        t_protect;
        t_nomatch;
        report_and_stop;
    end
endmodule
